// ==== rtl/backup_clock_and_reset_flags.sv ====
// Backup-domain control and reset-source registers behind an Avalon-MM slave.
// Assumes power_reset, backup_power_reset and event inputs come from ref_clk logic;
// oscillator ready lines, clocks and the reset pin are asynchronous pins.
//
// Behaviour
// RULE_01 - Backup control at 0x20, reset 0x18
// RULE_02 - Byte, half-word and word accesses accepted
// RULE_03 - Oscillator and RTC bits survive other resets
// RULE_04 - Protected bits writable only when unlocked
// RULE_05 - Backup reset bit holds domain in reset
// RULE_06 - RTC clock passes only while gate set
// RULE_07 - Source field selects none/slow/40k/fast-div128
// RULE_08 - Nonzero RTC source locks until backup reset
// RULE_09 - Drive field four levels, reset value 11
// RULE_10 - Drive strength not applied in bypass
// RULE_11 - Bypass bit takes external clock instead
// RULE_12 - Crystal runs on enable; stable flag reads back
// RULE_13 - Reset-source at 0x24, split reset domains
// RULE_14 - Low-power reset sets bit 31
// RULE_15 - Window watchdog reset sets bit 30
// RULE_16 - Free watchdog reset sets bit 29
// RULE_17 - Flag-clear bit clears all reset flags
// RULE_18 - Software, power, pin resets set 28/27/26
// RULE_19 - 40 kHz oscillator enable and stable flag
// RULE_20 - Stable flags drop while oscillator disabled
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module backup_clock_and_reset_flags #(
    parameter int SLOW_SETTLE = backup_clock_pkg::SLOW_XTAL_SETTLE_CYCLES,
    parameter int IRC_SETTLE  = backup_clock_pkg::IRC40K_SETTLE_CYCLES,
    parameter int RTC_DIVIDE  = backup_clock_pkg::HXTAL_DIVIDE
) (
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        power_reset,
    input  wire logic        backup_power_reset,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Power unit
    input  wire logic        backup_write_unlock,
    // Reset events
    input  wire logic        low_power_reset_event,
    input  wire logic        window_watchdog_reset_event,
    input  wire logic        free_watchdog_reset_event,
    input  wire logic        software_reset_event,
    input  wire logic        external_reset_pin,
    // Oscillator pins
    input  wire logic        slow_crystal_clock,
    input  wire logic        internal_40k_clock,
    input  wire logic        fast_crystal_clock,
    input  wire logic        slow_crystal_ready,
    input  wire logic        internal_40k_ready,
    // Oscillator and RTC controls
    output logic             slow_crystal_enable,
    output logic             slow_crystal_bypass,
    output logic [1:0]       slow_crystal_drive,
    output logic             internal_40k_osc_enable,
    output logic             backup_domain_reset,
    output logic             rtc_clock
);
    import backup_clock_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PINS = 6;
    localparam int P_SLOW = 0;
    localparam int P_IRC = 1;
    localparam int P_FAST = 2;
    localparam int P_SLOW_RDY = 3;
    localparam int P_IRC_RDY = 4;
    localparam int P_EXT = 5;

    wire  [PINS-1:0] pins_raw = {external_reset_pin, internal_40k_ready, slow_crystal_ready,
                                 fast_crystal_clock, internal_40k_clock, slow_crystal_clock};
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic            ext_prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pins_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                                input logic [3:0] be);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = new_w[8*i +: 8]; // [RULE_02]
            end
        end
        return m;
    endfunction

    logic        wait_q;
    logic [31:0] readdata_q;
    bdctl_s      bd_q;
    bdctl_s      bd_d;
    logic [5:0]  flags_q;
    logic [5:0]  flags_d;
    logic        clear_q;
    logic        irc_en_q;
    logic        drive_out_q;
    logic [1:0]  drive_q;
    logic        bd_reset_q;
    logic        slow_stable;
    logic        irc_stable;

    wire         sel_bd   = (avs_address[5:2] == BDCTL_OFFSET[5:2]);
    wire         sel_rs   = (avs_address[5:2] == RSTSCK_OFFSET[5:2]);
    wire         accept   = !wait_q && avs_write;
    wire         wr_bd    = accept && sel_bd;
    wire         wr_rs    = accept && sel_rs;

    wire  [31:0] bd_value = {15'h0, bd_q.bkp_rst, bd_q.rtc_gate, 5'h0, bd_q.rtc_src, 3'h0,
                             bd_q.drive, bd_q.bypass, slow_stable, bd_q.xtal_en};
    wire  [31:0] rs_value = {flags_q, 1'b0, clear_q, 22'h0, irc_stable, irc_en_q};
    wire  [31:0] rd_mux   = sel_bd ? bd_value : (sel_rs ? rs_value : 32'h00000000);
    wire  [31:0] bd_wr    = merge_bytes(bd_value, avs_writedata, avs_byteenable);
    wire  [31:0] rs_wr    = merge_bytes(rs_value, avs_writedata, avs_byteenable);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_q     <= 1'b1;
            readdata_q <= 32'h00000000;
        end else if (wait_q && (avs_read || avs_write)) begin
            wait_q     <= 1'b0;
            readdata_q <= avs_read ? rd_mux : 32'h00000000;
        end else begin
            wait_q     <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Backup control register
    // ------------------------------------------------------------
    wire bd_reset_now = backup_power_reset || bd_q.bkp_rst;

    always_comb begin
        bd_d = bd_q;
        if (wr_bd) begin
            bd_d.bkp_rst = bd_wr[BD_BKP_RST_BIT]; // [RULE_05]
            bd_d.drive   = bd_wr[BD_DRIVE_LSB +: 2]; // [RULE_09]
            if (backup_write_unlock) begin // [RULE_04]
                bd_d.xtal_en  = bd_wr[BD_XTAL_EN_BIT]; // [RULE_12]
                bd_d.bypass   = bd_wr[BD_BYPASS_BIT]; // [RULE_11]
                bd_d.rtc_gate = bd_wr[BD_GATE_BIT];
                if (bd_q.rtc_src == SRC_NONE) begin // [RULE_08]
                    bd_d.rtc_src = rtc_src_e'(bd_wr[BD_SRC_LSB +: 2]);
                end
            end
        end
        if (bd_reset_now) begin // [RULE_01]
            bd_d.rtc_gate = BDCTL_RESET[BD_GATE_BIT];
            bd_d.rtc_src  = rtc_src_e'(BDCTL_RESET[BD_SRC_LSB +: 2]);
            bd_d.drive    = BDCTL_RESET[BD_DRIVE_LSB +: 2];
            bd_d.bypass   = BDCTL_RESET[BD_BYPASS_BIT];
            bd_d.xtal_en  = BDCTL_RESET[BD_XTAL_EN_BIT];
        end
        if (backup_power_reset) begin
            bd_d.bkp_rst = BDCTL_RESET[BD_BKP_RST_BIT];
        end
    end

    // System reset deliberately absent: only the backup domain resets these
    always_ff @(posedge ref_clk) begin
        bd_q        <= bd_d; // [RULE_03]
        bd_reset_q  <= backup_power_reset || bd_d.bkp_rst;
        drive_q     <= bd_d.bypass ? 2'h0 : bd_d.drive; // [RULE_10]
        drive_out_q <= !bd_d.bypass;
    end

    // ------------------------------------------------------------
    // Reset-source register
    // ------------------------------------------------------------
    wire       clear_now = clear_q || (wr_rs && rs_wr[RS_CLEAR_BIT]);
    wire       ext_event = sync2_q[P_EXT] && !ext_prev_q;
    wire [5:0] events    = {low_power_reset_event, // [RULE_14]
                            window_watchdog_reset_event, // [RULE_15]
                            free_watchdog_reset_event, // [RULE_16]
                            software_reset_event, 1'b0, ext_event}; // [RULE_18]

    // A reset event in the clearing cycle survives the clear
    assign flags_d = power_reset ? FLAGS_RESET : ((flags_q & ~{6{clear_now}}) | events); // [RULE_17]

    always_ff @(posedge ref_clk) begin
        flags_q    <= flags_d; // [RULE_13]
        ext_prev_q <= sync2_q[P_EXT];
        if (reset || power_reset) begin
            clear_q  <= RSTSCK_RESET[RS_CLEAR_BIT];
            irc_en_q <= RSTSCK_RESET[RS_IRC_EN_BIT];
        end else if (wr_rs) begin
            clear_q  <= rs_wr[RS_CLEAR_BIT];
            irc_en_q <= rs_wr[RS_IRC_EN_BIT]; // [RULE_19]
        end
    end

    // ------------------------------------------------------------
    // Oscillator stability and RTC clock
    // ------------------------------------------------------------
    osc_settle #(
        .SETTLE_CYCLES (SLOW_SETTLE)
    ) u_slow_settle (
        .ref_clk  (ref_clk),
        .reset    (bd_reset_now),
        .enable   (bd_q.xtal_en),
        .ready    (sync2_q[P_SLOW_RDY]),
        .stable_q (slow_stable)
    );

    osc_settle #(
        .SETTLE_CYCLES (IRC_SETTLE)
    ) u_irc_settle (
        .ref_clk  (ref_clk),
        .reset    (reset || power_reset),
        .enable   (irc_en_q),
        .ready    (sync2_q[P_IRC_RDY]),
        .stable_q (irc_stable)
    );

    rtc_clock_mux #(
        .DIVIDE (RTC_DIVIDE)
    ) u_rtc_mux (
        .ref_clk     (ref_clk),
        .reset       (bd_reset_now),
        .slow_level  (sync2_q[P_SLOW]),
        .irc_level   (sync2_q[P_IRC]),
        .fast_level  (sync2_q[P_FAST]),
        .source      (bd_q.rtc_src),
        .gate        (bd_q.rtc_gate),
        .rtc_clock_q (rtc_clock)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata            = readdata_q;
    assign avs_waitrequest         = wait_q;
    assign slow_crystal_enable     = bd_q.xtal_en;
    assign slow_crystal_bypass     = bd_q.bypass;
    assign slow_crystal_drive      = drive_q;
    assign internal_40k_osc_enable = irc_en_q;
    assign backup_domain_reset     = bd_reset_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_bus_answer;
        !wait_q ##1 wait_q;
    endsequence

    property p_bus_answer;
        @(posedge ref_clk) disable iff (reset)
        wait_q && (avs_read || avs_write) |=> s_bus_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle late"); // [RULE_02]

    property p_byte_lane;
        @(posedge ref_clk) disable iff (reset)
        wr_bd && (avs_byteenable == 4'h1) && !backup_power_reset |=> $stable(bd_q.bkp_rst);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("unselected byte lane written"); // [RULE_02]

    property p_bd_reset_value;
        @(posedge ref_clk)
        backup_power_reset |=> (bd_value[31:2] == BDCTL_RESET[31:2]) && (bd_value[0] == 1'b0);
    endproperty
    a_bd_reset_value: assert property (p_bd_reset_value) else $error("backup reset value wrong"); // [RULE_01]

    property p_sys_reset_keeps;
        @(posedge ref_clk)
        reset && !bd_reset_now |=> $stable({bd_q.xtal_en, bd_q.bypass, bd_q.rtc_src, bd_q.rtc_gate});
    endproperty
    a_sys_reset_keeps: assert property (p_sys_reset_keeps) else $error("system reset touched backup bits"); // [RULE_03]

    property p_locked;
        @(posedge ref_clk) disable iff (reset)
        wr_bd && !backup_write_unlock && !bd_reset_now |=>
            $stable({bd_q.xtal_en, bd_q.bypass, bd_q.rtc_src, bd_q.rtc_gate});
    endproperty
    a_locked: assert property (p_locked) else $error("protected bit written while locked"); // [RULE_04]

    property p_held_reset;
        @(posedge ref_clk)
        bd_q.bkp_rst [*2] |-> bd_reset_q && !rtc_clock && !bd_q.xtal_en;
    endproperty
    a_held_reset: assert property (p_held_reset) else $error("backup domain left reset"); // [RULE_05]

    property p_gate_off;
        @(posedge ref_clk)
        !bd_q.rtc_gate |=> !rtc_clock;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("rtc clock passed while gated"); // [RULE_06]

    property p_src_lock;
        @(posedge ref_clk)
        (bd_q.rtc_src != SRC_NONE) && !bd_reset_now |=> $stable(bd_q.rtc_src);
    endproperty
    a_src_lock: assert property (p_src_lock) else $error("rtc source changed while locked"); // [RULE_08]

    property p_bypass_drive;
        @(posedge ref_clk)
        bd_q.bypass |-> (slow_crystal_drive == 2'h0) && !drive_out_q;
    endproperty
    a_bypass_drive: assert property (p_bypass_drive) else $error("drive applied in bypass"); // [RULE_10]

    property p_power_flags;
        @(posedge ref_clk)
        power_reset |=> (flags_q == FLAGS_RESET) && !irc_en_q && !clear_q;
    endproperty
    a_power_flags: assert property (p_power_flags) else $error("power reset value wrong"); // [RULE_13]

    property p_window_flag;
        @(posedge ref_clk) disable iff (reset)
        window_watchdog_reset_event && !power_reset |=> flags_q[FLAG_WINDOW_WDG];
    endproperty
    a_window_flag: assert property (p_window_flag) else $error("window watchdog flag not set"); // [RULE_15]

    property p_clear_all;
        @(posedge ref_clk) disable iff (reset)
        clear_now && !power_reset && (events == 6'h00) |=> (flags_q == 6'h00);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("flags not cleared"); // [RULE_17]

    property p_stable_drop;
        @(posedge ref_clk)
        !bd_q.xtal_en || !irc_en_q |=> (!bd_q.xtal_en -> !slow_stable) && (!irc_en_q -> !irc_stable);
    endproperty
    a_stable_drop: assert property (p_stable_drop) else $error("stable flag with oscillator off"); // [RULE_20]

endmodule

// ==== rtl/backup_clock_pkg.sv ====
// Constants, field layouts and types of the backup clock and reset-source block.
// Assumes a single 100 MHz clock; byte offsets on a 32-bit register bus.
package backup_clock_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0]  BDCTL_OFFSET  = 6'h20;
    localparam logic [5:0]  RSTSCK_OFFSET = 6'h24;
    localparam logic [31:0] BDCTL_RESET   = 32'h00000018;
    localparam logic [31:0] RSTSCK_RESET  = 32'h0C000000;

    // ------------------------------------------------------------
    // Field positions, backup control register
    // ------------------------------------------------------------
    localparam int BD_XTAL_EN_BIT  = 0;
    localparam int BD_XTAL_STB_BIT = 1;
    localparam int BD_BYPASS_BIT   = 2;
    localparam int BD_DRIVE_LSB    = 3;
    localparam int BD_SRC_LSB      = 8;
    localparam int BD_GATE_BIT     = 15;
    localparam int BD_BKP_RST_BIT  = 16;

    // ------------------------------------------------------------
    // Field positions, reset-source register
    // ------------------------------------------------------------
    localparam int RS_IRC_EN_BIT   = 0;
    localparam int RS_IRC_STB_BIT  = 1;
    localparam int RS_CLEAR_BIT    = 24;
    localparam int RS_FLAGS_LSB    = 26;
    localparam int FLAG_EXT_PIN    = 0;
    localparam int FLAG_POWER      = 1;
    localparam int FLAG_SOFTWARE   = 2;
    localparam int FLAG_FREE_WDG   = 3;
    localparam int FLAG_WINDOW_WDG = 4;
    localparam int FLAG_LOW_POWER  = 5;
    localparam logic [5:0] FLAGS_RESET = RSTSCK_RESET[31:26];

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int HXTAL_DIVIDE            = 128;
    localparam int SLOW_XTAL_SETTLE_CYCLES = 16;
    localparam int IRC40K_SETTLE_CYCLES    = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_NONE      = 2'b00,
        SRC_SLOW_XTAL = 2'b01,
        SRC_IRC40K    = 2'b10,
        SRC_HXTAL_DIV = 2'b11
    } rtc_src_e;

    typedef struct packed {
        logic       bkp_rst;
        logic       rtc_gate;
        rtc_src_e   rtc_src;
        logic [1:0] drive;
        logic       bypass;
        logic       xtal_en;
    } bdctl_s;

endpackage

// ==== rtl/osc_settle.sv ====
// Stability flag of one oscillator: counts settle cycles after enable and ready.
// Assumes ready is already synchronised to ref_clk.
`timescale 1ns/1ps
module osc_settle #(
    parameter int SETTLE_CYCLES = 16
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Oscillator
    input  wire logic enable,
    input  wire logic ready,
    output logic      stable_q
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

    logic [CW-1:0] count_q;
    wire           running = enable && ready;
    wire           done    = running && (count_q == LAST);

    // Flag drops at once when disabled and rises only after a full settle
    always_ff @(posedge ref_clk) begin
        if (reset || !running) begin
            count_q  <= '0;
            stable_q <= 1'b0; // [RULE_20]
        end else if (!stable_q) begin
            count_q  <= done ? count_q : count_q + 1'b1;
            stable_q <= done;
        end
    end
endmodule

// ==== rtl/rtc_clock_mux.sv ====
// RTC clock source selection, fast-crystal divider and output gate.
// Assumes the three clock levels are synchronised samples on ref_clk.
`timescale 1ns/1ps
module rtc_clock_mux #(
    parameter int DIVIDE = 128
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Source levels
    input  wire logic                 slow_level,
    input  wire logic                 irc_level,
    input  wire logic                 fast_level,
    // Control
    input  backup_clock_pkg::rtc_src_e source,
    input  wire logic                 gate,
    // Output
    output logic                      rtc_clock_q
);
    import backup_clock_pkg::*;

    localparam int HW = $clog2(DIVIDE / 2);
    localparam logic [HW-1:0] HALF_LAST = HW'(DIVIDE / 2 - 1);

    logic          fast_prev_q;
    logic          div_q;
    logic [HW-1:0] div_count_q;
    logic          selected;
    wire           fast_rise = fast_level && !fast_prev_q;

    // Divider toggles every half period of fast edges
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fast_prev_q <= 1'b0;
            div_q       <= 1'b0;
            div_count_q <= '0;
        end else begin
            fast_prev_q <= fast_level;
            if (fast_rise) begin
                div_count_q <= (div_count_q == HALF_LAST) ? '0 : div_count_q + 1'b1;
                div_q       <= (div_count_q == HALF_LAST) ? !div_q : div_q;
            end
        end
    end

    always_comb begin
        unique case (source)
            SRC_NONE:      selected = 1'b0; // [RULE_07]
            SRC_SLOW_XTAL: selected = slow_level;
            SRC_IRC40K:    selected = irc_level;
            SRC_HXTAL_DIV: selected = div_q;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rtc_clock_q <= 1'b0;
        end else begin
            rtc_clock_q <= gate && selected; // [RULE_06]
        end
    end
endmodule

// ==== verif/backup_clock_and_reset_flags_bench.sv ====
// Self-checking bench of the backup control and reset-source registers.
// Assumes osc_model on the oscillator pins and short settle and divide parameters.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module backup_clock_and_reset_flags_bench;
    import backup_clock_pkg::*;
    typedef struct {logic u; logic [5:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e; logic [31:0] m;} row_s;
    logic ref_clk = 0, reset = 1, power_reset = 1, backup_power_reset = 1, unlock = 0, pin = 0;
    logic [5:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [3:0] avs_byteenable = 0, ev = 0;
    logic avs_waitrequest, xen, xbyp, irc_en, bdr, rtc, sclk, iclk, fclk, srdy, irdy, prev;
    logic [1:0] drv;
    int errors = 0, checks_done = 0, n;
    row_s rows[9] = '{'{0, 6'h20, 32'h8119, 4'hF, 32'h18, '1}, '{1, 6'h20, 32'h10, 4'h1, 32'h10, '1},
        '{1, 6'h20, 32'h300, 4'h2, 32'h310, '1}, '{1, 6'h20, 32'h100, 4'h2, 32'h310, '1},
        '{1, 6'h20, 32'h8000, 4'h2, 32'h8310, '1}, '{1, 6'h24, 32'h1, 4'h1, 32'h0C000001, 32'hFFFFFFFD},
        '{1, 6'h24, '1, 4'hF, 32'h01000001, 32'hFFFFFFFD}, '{1, 6'h24, 32'h0, 4'h8, 32'h1, 32'hFFFFFFFD},
        '{1, 6'h00, '1, 4'hF, 32'h0, '1}};
    always #5 ref_clk = !ref_clk;
    backup_clock_and_reset_flags #(.SLOW_SETTLE(2), .IRC_SETTLE(2), .RTC_DIVIDE(4)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .power_reset(power_reset), .backup_power_reset(backup_power_reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .backup_write_unlock(unlock), .low_power_reset_event(ev[3]), .window_watchdog_reset_event(ev[2]),
        .free_watchdog_reset_event(ev[1]), .software_reset_event(ev[0]), .external_reset_pin(pin),
        .slow_crystal_clock(sclk), .internal_40k_clock(iclk), .fast_crystal_clock(fclk),
        .slow_crystal_ready(srdy), .internal_40k_ready(irdy), .slow_crystal_enable(xen),
        .slow_crystal_bypass(xbyp), .slow_crystal_drive(drv), .internal_40k_osc_enable(irc_en),
        .backup_domain_reset(bdr), .rtc_clock(rtc));
    osc_model u_osc (.ref_clk(ref_clk), .slow_crystal_enable(xen), .slow_crystal_bypass(xbyp),
        .internal_40k_osc_enable(irc_en), .slow_crystal_clock(sclk), .internal_40k_clock(iclk),
        .fast_crystal_clock(fclk), .slow_crystal_ready(srdy), .internal_40k_ready(irdy));
    // ------------------------------------------------------------
    // Bus cycles and helpers
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // Hold the request until waitrequest is sampled low; only the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        bus(0, a, 32'h0, 4'hF);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    task automatic edges(input int c);
        n = 0;
        repeat (c) begin
            @(negedge ref_clk);
            n += (rtc === 1'b1 && prev === 1'b0);
            prev = rtc;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        errors++;
        report_and_stop;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        reset <= 0;
        power_reset <= 0;
        backup_power_reset <= 0;
        rd(6'h20); `CHK(q, BDCTL_RESET)
        rd(6'h24); `CHK(q, RSTSCK_RESET)
        $display("reset values done");
        foreach (rows[i]) begin
            @(posedge ref_clk) unlock <= rows[i].u;
            bus(1, rows[i].a, rows[i].d, rows[i].be);
            rd(rows[i].a); `CHK(q & rows[i].m, rows[i].e)
        end
        cyc(30);
        rd(6'h24); `CHK({irc_en, q}, {1'b1, 32'h3})
        $display("register rows done");
        edges(256);
        `CHK(n >= 31 && n <= 33, 1'b1)
        bus(1, 6'h20, 32'h300, 4'h2);
        cyc(3);
        n = 0;
        repeat (20) begin
            @(negedge ref_clk) n += (rtc !== 1'b0);
        end
        `CHK(n, 0)
        $display("rtc clock done");
        bus(1, 6'h20, 32'h1C, 4'h1);
        cyc(2); `CHK({xbyp, drv}, 3'b100)
        bus(1, 6'h20, 32'h19, 4'h1);
        cyc(40); `CHK({xen, drv}, 3'b111)
        rd(6'h20); `CHK(q, 32'h31B)
        bus(1, 6'h20, 32'h18, 4'h1);
        rd(6'h20); `CHK(q, 32'h318)
        $display("slow crystal done");
        @(posedge ref_clk) reset <= 1;
        cyc(3);
        reset <= 0;
        rd(6'h20); `CHK(q, 32'h318)
        rd(6'h24); `CHK(q, 32'h0)
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) ev[i] <= 1;
            @(posedge ref_clk) ev[i] <= 0;
            rd(6'h24); `CHK(q[28 + i], 1'b1)
        end
        @(posedge ref_clk) pin <= 1;
        cyc(5);
        pin <= 0;
        cyc(5);
        rd(6'h24); `CHK(q, 32'hF4000000)
        @(posedge ref_clk) power_reset <= 1;
        @(posedge ref_clk) power_reset <= 0;
        rd(6'h24); `CHK(q, RSTSCK_RESET)
        $display("reset flags done");
        bus(1, 6'h20, 32'h10000, 4'h4);
        rd(6'h20); `CHK({bdr, q}, {1'b1, 32'h10018})
        bus(1, 6'h20, 32'h0, 4'h4);
        rd(6'h20); `CHK({bdr, q}, {1'b0, 32'h18})
        bus(1, 6'h20, 32'h100, 4'h2);
        rd(6'h20); `CHK(q, 32'h118)
        bus(1, 6'h20, 32'h8101, 4'h3);
        edges(64);
        `CHK(n >= 7 && n <= 9, 1'b1)
        $display("backup reset done");
        report_and_stop;
    end
endmodule

// ==== verif/osc_model.sv ====
// Oscillator pins seen by the block: slow crystal, internal 40 kHz and fast crystal.
// Assumes ref_clk at 100 MHz; clock levels change on ref_clk and are resynced by the block.
`timescale 1ns/1ps
module osc_model (
    // Clock
    input  wire logic ref_clk,
    // Controls from the block
    input  wire logic slow_crystal_enable,
    input  wire logic slow_crystal_bypass,
    input  wire logic internal_40k_osc_enable,
    // Oscillator outputs
    output logic      slow_crystal_clock,
    output logic      internal_40k_clock,
    output logic      fast_crystal_clock,
    output logic      slow_crystal_ready,
    output logic      internal_40k_ready
);
    int slow_n = 0;
    int irc_n  = 0;
    initial begin
        slow_crystal_clock = 1'b0;
        internal_40k_clock = 1'b0;
        fast_crystal_clock = 1'b0;
        slow_crystal_ready = 1'b0;
        internal_40k_ready = 1'b0;
    end
    // Ready only after a start-up delay; a stopped oscillator stands still
    always @(posedge ref_clk) begin
        slow_n = slow_crystal_enable ? slow_n + 1 : 0;
        irc_n  = internal_40k_osc_enable ? irc_n + 1 : 0;
        slow_crystal_ready <= slow_n > 5;
        internal_40k_ready <= irc_n > 5;
        fast_crystal_clock <= !fast_crystal_clock;
        if (slow_crystal_enable || slow_crystal_bypass) begin
            slow_crystal_clock <= (slow_n % 8) < 4;
        end
        if (internal_40k_osc_enable) begin
            internal_40k_clock <= (irc_n % 12) < 6;
        end
    end
endmodule
